// *** core/sdw_pkg.sv ***
// Overview of operation
// - Write latency is read latency minus one command clock cycle.
// - Write command gives bank, column and auto precharge; precharge after burst.
// - First element on first strobe rise, then one element per strobe edge.
// - After a burst with nothing pending, data lines stay undriven, extra data ignored.
// - Burst of eight without auto precharge is cut only by a write, on group boundary.
// - The interrupting write may use any bank, row and auto precharge choice.
// - Elements after the first go to successive columns in burst order.
// - Auto precharge recovery cycle count comes from a mode register field.
package sdw_pkg;
   localparam int DQ_W = 8;
   localparam int BANK_W = 3;
   localparam int COL_W = 10;
   localparam int ADDR_W = 14;
   localparam int GRP_N = 4;
   localparam int AP_BIT = 10;
   localparam int RA_W = 4;
   localparam int SYNC_W = 32;
   // Latency and interruption figures in command clock cycles
   localparam logic [3:0] LAT_OFFSET = 4'h1;
   localparam logic [3:0] INTR_AGE = 4'h2;
   localparam logic [3:0] AGE_MAX = 4'hf;
   // Register offsets
   localparam logic [RA_W-1:0] REG_CFG = 4'h0;
   localparam logic [RA_W-1:0] REG_STAT = 4'h4;
   localparam logic [RA_W-1:0] REG_GCNT = 4'h8;
   // Configuration field positions and reset values
   localparam int CFG_CAS_LSB = 0;
   localparam int CFG_ADD_LSB = 4;
   localparam int CFG_BL8_BIT = 8;
   localparam int CFG_WR_LSB = 12;
   localparam logic [2:0] CFG_CAS_RST = 3'h3;
   localparam logic [2:0] CFG_ADD_RST = 3'h0;
   localparam logic CFG_BL8_RST = 1'b0;
   localparam logic [2:0] CFG_WR_RST = 3'h3;
   // Status bit positions
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_PEND_BIT = 1;
   localparam int STAT_AP_BIT = 2;

   typedef struct packed {
      logic ck;
      logic dqs;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] dq;
      logic dm;
   } sdw_pin_s;

   typedef struct packed {
      logic [2:0] cas_latency;
      logic [2:0] additive_latency;
      logic bl8;
      logic [2:0] wr_cycles;
   } sdw_cfg_s;

   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0] col;
      logic [GRP_N*DQ_W-1:0] data;
      logic [GRP_N-1:0] mask;
   } sdw_grp_s;

   typedef struct packed {
      logic busy;
      logic pend;
      logic ap_run;
      logic [15:0] grp_cnt;
   } sdw_stat_s;

   typedef enum logic [2:0] {
      SDW_IDLE = 3'b001,
      SDW_PRE = 3'b010,
      SDW_DATA = 3'b100
   } sdw_phase_e;
endpackage

// *** core/sdw_sync.sv ***
`timescale 1ns/1ps
module sdw_sync #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stb;
   } sdw_sync_s;

   sdw_sync_s st_r;
   sdw_sync_s st_nxt;

   // Three stages; a bit changes once stages two and three agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.stb = ((st_r.s2 ~^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.stb);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.stb;
endmodule

// *** core/sdw_regs.sv ***
`timescale 1ns/1ps
module sdw_regs
   import sdw_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [sdw_pkg::RA_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output sdw_pkg::sdw_cfg_s cfg,
   input sdw_pkg::sdw_stat_s stat
);
   typedef struct packed {
      sdw_cfg_s cfg;
      logic [31:0] rdata;
   } sdw_regs_s;

   sdw_regs_s st_r;
   sdw_regs_s st_nxt;

   // Configuration write and one-cycle read answer
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = '0;
      if (reg_wr && reg_addr == REG_CFG) begin
         st_nxt.cfg.cas_latency = reg_wdata[CFG_CAS_LSB +: 3];
         st_nxt.cfg.additive_latency = reg_wdata[CFG_ADD_LSB +: 3];
         st_nxt.cfg.bl8 = reg_wdata[CFG_BL8_BIT];
         st_nxt.cfg.wr_cycles = reg_wdata[CFG_WR_LSB +: 3];
      end
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CFG: begin
               st_nxt.rdata[CFG_CAS_LSB +: 3] = st_r.cfg.cas_latency;
               st_nxt.rdata[CFG_ADD_LSB +: 3] = st_r.cfg.additive_latency;
               st_nxt.rdata[CFG_BL8_BIT] = st_r.cfg.bl8;
               st_nxt.rdata[CFG_WR_LSB +: 3] = st_r.cfg.wr_cycles;
            end
            REG_STAT: begin
               st_nxt.rdata[STAT_BUSY_BIT] = stat.busy;
               st_nxt.rdata[STAT_PEND_BIT] = stat.pend;
               st_nxt.rdata[STAT_AP_BIT] = stat.ap_run;
            end
            REG_GCNT: begin
               st_nxt.rdata[15:0] = stat.grp_cnt;
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r.cfg.cas_latency <= CFG_CAS_RST;
         st_r.cfg.additive_latency <= CFG_ADD_RST;
         st_r.cfg.bl8 <= CFG_BL8_RST;
         st_r.cfg.wr_cycles <= CFG_WR_RST;
         st_r.rdata <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cfg = st_r.cfg;
   assign reg_rdata = st_r.rdata;

   // Recovery field written by software lands unchanged
   property p_wr_field;
      @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == REG_CFG) |=> cfg.wr_cycles == $past(reg_wdata[CFG_WR_LSB +: 3]);
   endproperty
   a_wr_field: assert property (p_wr_field) else $error("recovery field not stored");

   // Unmapped reads answer zero
   property p_rd_unmapped;
      @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr != REG_CFG && reg_addr != REG_STAT && reg_addr != REG_GCNT)
         |=> reg_rdata == 32'h0;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
endmodule

// *** core/sdw_write_core.sv ***
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module sdw_write_core
   import sdw_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input sdw_pkg::sdw_pin_s pins,
   output logic [sdw_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [sdw_pkg::RA_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output sdw_pkg::sdw_grp_s commit,
   output logic commit_valid,
   output logic precharge_valid,
   output logic [sdw_pkg::BANK_W-1:0] precharge_bank
);
   typedef struct packed {
      sdw_phase_e phase;
      logic ck_q;
      logic dqs_q;
      logic [3:0] age;
      logic [3:0] elem;
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0] col;
      logic ap;
      logic bl8;
      logic trunc;
      logic pend;
      logic [BANK_W-1:0] pbank;
      logic [COL_W-1:0] pcol;
      logic pap;
      logic [3:0] page;
      logic [(GRP_N-1)*DQ_W-1:0] gdata;
      logic [GRP_N-2:0] gmask;
      logic ap_run;
      logic [BANK_W-1:0] ap_bank;
      logic [3:0] ap_cnt;
      sdw_grp_s commit;
      logic commit_v;
      logic pre_v;
      logic [BANK_W-1:0] pre_bank;
      logic [15:0] grp_cnt;
   } sdw_core_s;

   sdw_core_s st_r;
   sdw_core_s st_nxt;
   sdw_pin_s pin;
   sdw_cfg_s cfg;
   sdw_stat_s stat;
   logic ck_rise;
   logic dqs_rise;
   logic dqs_edge;
   logic wr_cmd;
   logic [3:0] write_latency;
   logic lat_reached;
   logic last;

   // All pins cross into the core clock together
   sdw_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .d(pins),
      .q(pin)
   );

   // Software-visible configuration and status
   sdw_regs u_regs (
      .clk(clk),
      .srst(srst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .cfg(cfg),
      .stat(stat)
   );

   // Edges of the command clock and the strobe
   assign ck_rise = pin.ck & ~st_r.ck_q;
   assign dqs_rise = pin.dqs & ~st_r.dqs_q;
   assign dqs_edge = pin.dqs ^ st_r.dqs_q;
   assign wr_cmd = ~pin.cs_n & pin.ras_n & ~pin.cas_n & ~pin.we_n;

   // Write latency from read latency
   assign write_latency = {1'b0, cfg.cas_latency} + {1'b0, cfg.additive_latency}
      - LAT_OFFSET;
   assign lat_reached = (st_r.age + 4'h1) >= write_latency;

   // Main write-burst sequencer
   always_comb begin
      st_nxt = st_r;
      last = 1'b0;
      st_nxt.commit_v = 1'b0;
      st_nxt.pre_v = 1'b0;
      st_nxt.ck_q = pin.ck;
      st_nxt.dqs_q = pin.dqs;
      if (ck_rise) begin
         // Age of the running and pending commands in clock cycles
         if (st_r.phase != SDW_IDLE && st_r.age != AGE_MAX) begin
            st_nxt.age = st_r.age + 4'h1;
         end
         if (st_r.pend && st_r.page != AGE_MAX) begin
            st_nxt.page = st_r.page + 4'h1;
         end
         // Auto precharge recovery countdown
         if (st_r.ap_run) begin
            if (st_r.ap_cnt <= 4'h1) begin
               st_nxt.ap_run = 1'b0;
               st_nxt.pre_v = 1'b1;
               st_nxt.pre_bank = st_r.ap_bank;
            end else begin
               st_nxt.ap_cnt = st_r.ap_cnt - 4'h1;
            end
         end
         if (wr_cmd) begin
            if (st_r.phase == SDW_IDLE) begin
               // Fresh burst: latch bank, column, precharge choice
               st_nxt.phase = SDW_PRE;
               st_nxt.age = 4'h0;
               st_nxt.elem = 4'h0;
               st_nxt.trunc = 1'b0;
               st_nxt.bank = pin.bank;
               st_nxt.col = pin.addr[COL_W-1:0];
               st_nxt.ap = pin.addr[AP_BIT];
               st_nxt.bl8 = cfg.bl8;
            end else if (!st_r.pend) begin
               // Next write queued; any bank, any precharge choice
               st_nxt.pend = 1'b1;
               st_nxt.page = 4'h0;
               st_nxt.pbank = pin.bank;
               st_nxt.pcol = pin.addr[COL_W-1:0];
               st_nxt.pap = pin.addr[AP_BIT];
               // Cut at the group boundary only for eight, no precharge
               if (st_r.bl8 && !st_r.ap && st_nxt.age == INTR_AGE) begin
                  st_nxt.trunc = 1'b1;
               end
            end
         end
      end
      // Capture on strobe edges; preamble and idle edges are ignored
      if (dqs_edge && (st_r.phase == SDW_DATA ||
          (st_r.phase == SDW_PRE && dqs_rise && lat_reached))) begin
         st_nxt.phase = SDW_DATA;
         st_nxt.elem = st_r.elem + 4'h1;
         if (st_r.elem[1:0] != 2'h3) begin
            st_nxt.gdata[{st_r.elem[1:0], 3'b000} +: DQ_W] = pin.dq;
            st_nxt.gmask[st_r.elem[1:0]] = pin.dm;
         end else begin
            // Group of four complete: commit to the open row
            st_nxt.commit_v = 1'b1;
            st_nxt.grp_cnt = st_r.grp_cnt + 16'h1;
            st_nxt.commit.bank = st_r.bank;
            st_nxt.commit.col = {st_r.col[COL_W-1:3], st_r.col[2] ^ st_r.elem[2],
                                 st_r.col[1:0]};
            st_nxt.commit.data = {pin.dq, st_r.gdata};
            st_nxt.commit.mask = {pin.dm, st_r.gmask};
            last = !st_r.bl8 || st_nxt.trunc || st_r.elem[2];
         end
         if (last) begin
            // Burst end: arm precharge, then start pending or go idle
            if (st_r.ap && !st_nxt.trunc) begin
               st_nxt.ap_run = 1'b1;
               st_nxt.ap_cnt = {1'b0, cfg.wr_cycles};
               st_nxt.ap_bank = st_r.bank;
            end
            st_nxt.elem = 4'h0;
            st_nxt.trunc = 1'b0;
            if (st_nxt.pend) begin
               st_nxt.phase = SDW_PRE;
               st_nxt.pend = 1'b0;
               st_nxt.age = st_nxt.page;
               st_nxt.bank = st_nxt.pbank;
               st_nxt.col = st_nxt.pcol;
               st_nxt.ap = st_nxt.pap;
               st_nxt.bl8 = cfg.bl8;
            end else begin
               st_nxt.phase = SDW_IDLE;
               st_nxt.age = 4'h0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
         st_r.phase <= SDW_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs and status
   assign commit = st_r.commit;
   assign commit_valid = st_r.commit_v;
   assign precharge_valid = st_r.pre_v;
   assign precharge_bank = st_r.pre_bank;
   assign dq_out = '0;
   assign dq_oe = 1'b0;
   assign stat = '{busy: st_r.phase != SDW_IDLE, pend: st_r.pend, ap_run: st_r.ap_run,
                   grp_cnt: st_r.grp_cnt};

   // First element no earlier than one cycle before write latency
   property p_first_latency;
      @(posedge clk) disable iff (srst)
      (st_r.phase == SDW_PRE && st_nxt.phase == SDW_DATA)
         |-> (st_r.age + 4'h1 >= write_latency) && dqs_rise;
   endproperty
   a_first_latency: assert property (p_first_latency) else $error("early first element");

   // Precharge arms with the burst's own bank
   property p_ap_bank;
      @(posedge clk) disable iff (srst)
      $rose(st_r.ap_run) |-> st_r.ap_bank == $past(st_r.bank) && $past(st_r.ap);
   endproperty
   a_ap_bank: assert property (p_ap_bank) else $error("precharge bank wrong");

   // Commit follows the fourth captured strobe edge
   property p_group_four;
      @(posedge clk) disable iff (srst)
      commit_valid |-> $past(st_r.elem[1:0]) == 2'h3 && $past(dqs_edge);
   endproperty
   a_group_four: assert property (p_group_four) else $error("commit not on fourth element");

   // Idle core ignores strobe and data
   property p_idle_quiet;
      @(posedge clk) disable iff (srst)
      (st_r.phase == SDW_IDLE) |=> !commit_valid && st_r.elem == 4'h0;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("data taken while idle");

   // Truncation only for eight, no precharge, second cycle
   property p_trunc_only;
      @(posedge clk) disable iff (srst)
      $rose(st_r.trunc) |-> st_r.bl8 && !st_r.ap && st_r.age == INTR_AGE && st_r.pend;
   endproperty
   a_trunc_only: assert property (p_trunc_only) else $error("illegal truncation");

   // Pending write takes over with its own bank and choice
   property p_switch;
      @(posedge clk) disable iff (srst)
      (st_r.phase == SDW_DATA && st_nxt.phase == SDW_PRE)
         |=> st_r.bank == $past(st_r.pbank) && st_r.ap == $past(st_r.pap);
   endproperty
   a_switch: assert property (p_switch) else $error("pending write lost");

   // Second group of eight goes to the other column half
   property p_col_order;
      @(posedge clk) disable iff (srst)
      (commit_valid && $past(st_r.elem[2])) |-> commit.col[2] != $past(st_r.col[2]);
   endproperty
   a_col_order: assert property (p_col_order) else $error("column order wrong");

   // Precharge fires only when the recovery count runs out
   property p_pre_cnt;
      @(posedge clk) disable iff (srst)
      precharge_valid |-> $past(st_r.ap_cnt) <= 4'h1 && $past(ck_rise) && !st_r.ap_run;
   endproperty
   a_pre_cnt: assert property (p_pre_cnt) else $error("precharge before recovery");

   // Commit data carries the element seen on the closing edge
   property p_commit_data;
      @(posedge clk) disable iff (srst)
      commit_valid |-> commit.data[GRP_N*DQ_W-1 -: DQ_W] == $past(pin.dq);
   endproperty
   a_commit_data: assert property (p_commit_data) else $error("group data wrong");
endmodule

// *** dv/sdw_ctrl_model.sv ***
`timescale 1ns/1ps
module sdw_ctrl_model (
   output sdw_pkg::sdw_pin_s pins
);
   import sdw_pkg::*;

   sdw_pin_s p;

   assign pins = p;

   // Free-running command clock, 48 ns period; bus starts deselected
   initial begin
      p = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0, 8'h0, 1'b0};
      forever #24 p.ck = ~p.ck;
   end

   // One write command seen on one ck rise, deselect around it
   task automatic cmd(input logic [2:0] b, input logic [9:0] c, input logic ap);
      @(negedge p.ck);
      {p.cs_n, p.ras_n, p.cas_n, p.we_n} = 4'h4;
      p.bank = b;
      p.addr = {3'h0, ap, c};
      @(negedge p.ck);
      {p.cs_n, p.ras_n, p.cas_n, p.we_n} = 4'hf;
      p.addr = ~p.addr;
   endtask

   // First write, optional second write gap ck later, then a contiguous data stream
   // No read or precharge is ever issued by this model
   task automatic seq(input logic [2:0] b0, input logic [9:0] c0, input logic ap0,
      input int gap, input logic [2:0] b1, input logic [9:0] c1, input logic ap1,
      input int n, input int lat, input logic [7:0] base, input logic [3:0] msk);
      fork
         begin
            cmd(b0, c0, ap0);
            if (gap > 0) begin
               // Only deselect fills the gap
               repeat (gap - 2) @(negedge p.ck);
               cmd(b1, c1, ap1);
            end
         end
         begin
            @(negedge p.ck);
            @(posedge p.ck);
            // Strobe low as preamble, first rise on the ck rise lat later
            #(lat * 48 - 12);
            for (int i = 0; i < n; i++) begin
               p.dq = base + 8'(i);
               p.dm = msk[i % 4];
               #12 p.dqs = ~p.dqs;
               #12;
            end
            // Strobe stays low as postamble, data inverted and mask cleared
            p.dq = ~p.dq;
            p.dm = 1'b0;
         end
      join
   endtask

   // Strobe and data activity with no write command
   task automatic stray();
      for (int i = 0; i < 8; i++) begin
         p.dq = 8'h5a ^ 8'(i);
         #12 p.dqs = ~p.dqs;
         #12;
      end
   endtask
endmodule

// *** dv/sdw_write_burst_timing_test.sv ***
`timescale 1ns/1ps
module sdw_write_burst_timing_test;
   import sdw_pkg::*;

   logic clk;
   logic srst;
   sdw_pin_s pins;
   logic [DQ_W-1:0] dq_out;
   logic dq_oe;
   logic [RA_W-1:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   sdw_grp_s commit;
   logic commit_valid;
   logic precharge_valid;
   logic [BANK_W-1:0] precharge_bank;
   int miscompares = 0;
   int checked = 0;
   sdw_grp_s cq[$];
   logic [BANK_W-1:0] pq[$];
   localparam int LAT_RST = int'(CFG_CAS_RST) + int'(CFG_ADD_RST) - 1;
   localparam logic [31:0] CFG_RST_WORD = {17'h0, CFG_WR_RST, 3'h0, CFG_BL8_RST, 1'b0,
      CFG_ADD_RST, 1'b0, CFG_CAS_RST};

   sdw_write_core DUT (
      .clk(clk),
      .srst(srst),
      .pins(pins),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .commit(commit),
      .commit_valid(commit_valid),
      .precharge_valid(precharge_valid),
      .precharge_bank(precharge_bank)
   );

   sdw_ctrl_model ctrl (
      .pins(pins)
   );

   // Core clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Collect committed groups and auto precharge starts
   always @(posedge clk) begin
      if (commit_valid === 1'b1) cq.push_back(commit);
      if (precharge_valid === 1'b1) pq.push_back(precharge_bank);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [RA_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [RA_W-1:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask

   // Bounded wait for n committed groups
   task automatic wait_cq(input int n);
      for (int i = 0; i < 400 && cq.size() < n; i++) @(posedge clk);
      chk(32'(cq.size()), 32'(n));
   endtask

   // Compare the oldest committed group with four elements from base
   task automatic exp_grp(input logic [2:0] b, input logic [9:0] c, input logic [7:0] base,
      input logic [3:0] msk);
      sdw_grp_s g;
      if (cq.size() == 0) begin
         chk(32'h0, 32'h1);
         return;
      end
      g = cq.pop_front();
      chk(32'(g.bank), 32'(b));
      chk(32'(g.col), 32'(c));
      chk(g.data, {base + 8'h3, base + 8'h2, base + 8'h1, base});
      chk(32'(g.mask), 32'(msk));
   endtask

   // Bounded wait for one auto precharge start on bank b
   task automatic exp_pre(input logic [2:0] b);
      for (int i = 0; i < 400 && pq.size() < 1; i++) @(posedge clk);
      chk(32'(pq.size()), 32'h1);
      if (pq.size() > 0) chk(32'(pq.pop_front()), 32'(b));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #100000;
      miscompares++;
      summarize();
   end

   // Test sequence
   initial begin
      srst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      // Reset values, unmapped and read-only places
      rd_reg(REG_CFG, CFG_RST_WORD);
      rd_reg(REG_STAT, 32'h0);
      rd_reg(REG_GCNT, 32'h0);
      rd_reg(4'hc, 32'h0);
      wr_reg(REG_STAT, 32'hffff_ffff);
      rd_reg(REG_STAT, 32'h0);
      // Strobe edges while idle commit nothing
      ctrl.stray();
      repeat (60) @(posedge clk);
      chk(32'(cq.size()), 32'h0);
      // Single burst of four with a masked element
      ctrl.seq(3'h1, 10'h010, 1'b0, 0, 3'h0, 10'h0, 1'b0, 4, LAT_RST, 8'h10, 4'h2);
      wait_cq(1);
      exp_grp(3'h1, 10'h010, 8'h10, 4'h2);
      chk(32'(dq_oe), 32'h0);
      chk(32'(dq_out), 32'h0);
      // Burst of four with auto precharge
      ctrl.seq(3'h5, 10'h020, 1'b1, 0, 3'h0, 10'h0, 1'b0, 4, LAT_RST, 8'h20, 4'h0);
      wait_cq(1);
      exp_grp(3'h5, 10'h020, 8'h20, 4'h0);
      exp_pre(3'h5);
      // Gapless bursts of four to two banks
      ctrl.seq(3'h2, 10'h040, 1'b0, 2, 3'h6, 10'h3f8, 1'b0, 8, LAT_RST, 8'h40, 4'h0);
      wait_cq(2);
      exp_grp(3'h2, 10'h040, 8'h40, 4'h0);
      exp_grp(3'h6, 10'h3f8, 8'h44, 4'h0);
      // Burst of eight, cas 4 and additive 1, so write latency 4
      wr_reg(REG_CFG, 32'h0000_3114);
      rd_reg(REG_CFG, 32'h0000_3114);
      ctrl.seq(3'h4, 10'h100, 1'b0, 0, 3'h0, 10'h0, 1'b0, 8, 4, 8'h60, 4'h9);
      wait_cq(2);
      exp_grp(3'h4, 10'h100, 8'h60, 4'h9);
      exp_grp(3'h4, 10'h104, 8'h64, 4'h9);
      // Burst of eight cut by a write two ck later, second with auto precharge
      ctrl.seq(3'h0, 10'h200, 1'b0, 2, 3'h7, 10'h300, 1'b1, 12, 4, 8'h80, 4'h0);
      wait_cq(3);
      exp_grp(3'h0, 10'h200, 8'h80, 4'h0);
      exp_grp(3'h7, 10'h300, 8'h84, 4'h0);
      exp_grp(3'h7, 10'h304, 8'h88, 4'h0);
      exp_pre(3'h7);
      // Group count and quiet status at the end
      rd_reg(REG_GCNT, 32'd9);
      rd_reg(REG_STAT, 32'h0);
      // No stray precharge or group left over
      chk(32'(pq.size()), 32'h0);
      chk(32'(cq.size()), 32'h0);
      summarize();
   end
endmodule
